// ==== verilog/sgpsc_pkg.sv ====
// Purpose: constants and types of the global port and storm config bank
// Assumes: 40 MHz single clock, registers reached over APB
// Notes:   offsets are word indices; byte address is four times the index
// ---------------------------------------------------------------------------
// Operation
// RULE1: bit 7 enables repeater mode, resets 0
// RULE2: software sets all ports 100Base-TX half duplex
// RULE3: software disables PHY auto-negotiation in repeater mode
// RULE4: bit 6 half duplex, reset from strap
// RULE5: bit 5 flow control, reset from strap
// RULE6: bit 4 selects 10Mbps, clear 100Mbps
// RULE7: speed bit loaded from speed strap
// RULE8: bit 3 replaces null VID with port VID
// RULE9: threshold is bits 2:0 joined with next register
// RULE10: interval 67ms at 100BT, 500ms at 10BT
// RULE11: threshold resets to 000 and 0x63
// RULE12: software keeps factory test registers at reset
// RULE13: over-threshold port drops broadcast until next interval
// ---------------------------------------------------------------------------
package sgpsc_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000; // system clock rate
  localparam int unsigned TICK_MS         = 1;          // divider tick period
  localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned STORM_100_MS    = 67;         // 100BT interval
  localparam int unsigned STORM_10_MS     = 500;        // 10BT interval
  localparam int unsigned STORM_100_TICKS = STORM_100_MS / TICK_MS;
  localparam int unsigned STORM_10_TICKS  = STORM_10_MS / TICK_MS;

  // ---------------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_MODE_HI  = 6'h06; // repeater, mii, storm high
  localparam logic [5:0] IDX_STORM_LO = 6'h07; // storm threshold low byte
  localparam logic [5:0] IDX_FTEST_A  = 6'h08; // factory test a
  localparam logic [5:0] IDX_FTEST_B  = 6'h09; // factory test b
  localparam logic [5:0] IDX_FTEST_C  = 6'h0A; // factory test c
  localparam logic [5:0] IDX_STATUS   = 6'h10; // per-port drop flags, RO

  // ---------------------------------------------------------------------------
  // field positions of the mode register
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_REPEATER = 7;
  localparam int unsigned BIT_HALF_DUP = 6;
  localparam int unsigned BIT_FLOW_EN  = 5;
  localparam int unsigned BIT_SPEED10  = 4;
  localparam int unsigned BIT_NULL_VID = 3;
  localparam int unsigned STORM_HI_MSB = 2;
  localparam int unsigned THR_W        = 11; // threshold width
  localparam int unsigned VID_W        = 12; // vlan identifier width

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic       RST_REPEATER = 1'b0;
  localparam logic       RST_NULL_VID = 1'b0;
  localparam logic [2:0] RST_STORM_HI = 3'h0;
  localparam logic [7:0] RST_STORM_LO = 8'h63;
  localparam logic [7:0] RST_FTEST_A  = 8'h00;
  localparam logic [7:0] RST_FTEST_B  = 8'h24;
  localparam logic [7:0] RST_FTEST_C  = 8'h35;

  // ---------------------------------------------------------------------------
  // configuration carrier
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             repeater; // repeater mode on
    logic             half_dup; // mii half duplex
    logic             flow_en;  // mii full-duplex flow control
    logic             speed10;  // mii at 10Mbps
    logic             null_vid; // null vid replacement
    logic [THR_W-1:0] storm_thr;// storm threshold in 64-byte blocks
  } sgpsc_cfg_t;

endpackage

// ==== verilog/sgpsc_storm.sv ====
// Purpose: per-port broadcast storm interval counting and drop decision
// Assumes: blk_i pulses once per 64-byte block of broadcast data
// Notes:   interval is timed in divider ticks, one timer per port
`timescale 1ns/10ps
module sgpsc_storm
  import sgpsc_pkg::*;
#(
  parameter int unsigned NPORTS = 3,  // switch ports
  parameter int unsigned PER_W  = 9,  // interval tick counter width
  parameter int unsigned BLK_W  = 12  // block counter width
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // timing and threshold
  input  wire logic             tick_i,
  input  wire logic [THR_W-1:0] thr_i,
  // per-port activity
  input  wire logic [NPORTS-1:0] port_10_i,
  input  wire logic [NPORTS-1:0] blk_i,
  output logic      [NPORTS-1:0] drop_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [PER_W-1:0] tick_cnt [NPORTS]; // ticks elapsed in interval
  logic [BLK_W-1:0] blk_cnt  [NPORTS]; // blocks seen in interval
  logic [NPORTS-1:0] ivl_end;          // last tick of the interval

  // interval length in ticks for the port speed
  function automatic logic [PER_W-1:0] ivl_len(input logic is10);
    ivl_len = is10 ? PER_W'(STORM_10_TICKS) : PER_W'(STORM_100_TICKS);
  endfunction

  // interval end decode
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      ivl_end[p] = tick_i && (tick_cnt[p] >= ivl_len(port_10_i[p]) - 1'b1);
    end
  end

  // interval timers, see RULE10
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (!rst_n_i) begin
        tick_cnt[p] <= '0;
      end else if (ivl_end[p]) begin
        tick_cnt[p] <= '0;
      end else if (tick_i) begin
        tick_cnt[p] <= tick_cnt[p] + 1'b1;
      end
    end
  end

  // block counters; saturate so a long storm cannot wrap back under
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (!rst_n_i) begin
        blk_cnt[p] <= '0;
      end else if (ivl_end[p]) begin
        blk_cnt[p] <= BLK_W'(blk_i[p]);
      end else if (blk_i[p] && !(&blk_cnt[p])) begin
        blk_cnt[p] <= blk_cnt[p] + 1'b1;
      end
    end
  end

  // drop once the count exceeds the threshold, see RULE13 RULE9
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NPORTS; p++) begin
      if (!rst_n_i) begin
        drop_o[p] <= 1'b0;
      end else if (ivl_end[p]) begin
        drop_o[p] <= 1'b0;
      end else if (blk_cnt[p] > BLK_W'(thr_i)) begin
        drop_o[p] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_drop_cause: assert property ( // see RULE13
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(drop_o[0]) |-> $past(blk_cnt[0]) > BLK_W'($past(thr_i)))
    else $error("drop raised without threshold exceeded");

  a_drop_holds: assert property ( // see RULE13
    @(posedge clk_i) disable iff (!rst_n_i)
    drop_o[0] && !ivl_end[0] |=> drop_o[0])
    else $error("drop released inside interval");

  a_interval_end: assert property ( // see RULE10
    @(posedge clk_i) disable iff (!rst_n_i)
    ivl_end[0] |=> tick_cnt[0] == '0 && !drop_o[0])
    else $error("interval end did not restart port");

endmodule

// ==== verilog/sgpsc_top.sv ====
// Purpose: global repeater, switch mii and storm threshold register bank
// Assumes: APB slave, zero wait states, straps held stable during reset
// Notes:   reset must stay low at least five edges to latch the straps
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module sgpsc_top
  import sgpsc_pkg::*;
#(
  parameter int unsigned NPORTS    = 3,        // switch ports
  parameter int unsigned TICK_CYCS = TICK_CYC  // cycles per divider tick
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  input  wire logic [3:0]        PSTRB_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // strap pins
  input  wire logic              DUPLEX_STRAP_PIN_I,
  input  wire logic              FLOW_CTRL_STRAP_PIN_I,
  input  wire logic              SPEED_STRAP_PIN_I,
  // mode outputs
  output logic                   REPEATER_EN_O,
  output logic                   MII_HALF_DUPLEX_O,
  output logic                   MII_FLOW_CTRL_O,
  output logic                   MII_SPEED_10_O,
  output logic      [THR_W-1:0]  STORM_THRESH_O,
  // storm protection
  input  wire logic [NPORTS-1:0] PORT_SPEED_10_I,
  input  wire logic [NPORTS-1:0] BCAST_BLK_I,
  output logic      [NPORTS-1:0] BCAST_DROP_O,
  // vid replacement path
  input  wire logic              VID_VALID_I,
  input  wire logic [VID_W-1:0]  VID_I,
  input  wire logic [VID_W-1:0]  PORT_VID_I,
  output logic                   VID_VALID_O,
  output logic      [VID_W-1:0]  VID_O
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  sgpsc_cfg_t  cfg;          // live configuration
  logic [7:0]  ftest_a;      // factory test a
  logic [7:0]  ftest_b;      // factory test b
  logic [7:0]  ftest_c;      // factory test c
  logic [2:0]  strap_s1;     // strap sync stage 1
  logic [2:0]  strap_s2;     // strap sync stage 2
  logic [2:0]  strap_s3;     // strap sync stage 3
  logic [2:0]  strap_f;      // filtered strap level
  logic [5:0]  idx;          // word index of the access
  logic        mapped;       // address hits a register
  logic        wr_en;        // write in access phase
  logic        rd_setup;     // read in setup phase
  logic [7:0]  rd_byte;      // read mux result
  logic [7:0]  wbyte;        // low write lane
  localparam int unsigned DIV_W = $clog2(TICK_CYCS); // divider width
  logic [DIV_W-1:0] div_cnt; // tick divider
  logic        tick;         // one-cycle tick enable

  // decode of a register index from an apb address
  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i == IDX_MODE_HI) || (i == IDX_STORM_LO) ||
                (i == IDX_FTEST_A) || (i == IDX_FTEST_B)  ||
                (i == IDX_FTEST_C) || (i == IDX_STATUS);
  endfunction

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  // misaligned addresses are treated as unmapped
  assign idx       = PADDR_I[7:2];
  assign mapped    = is_mapped(idx) && (PADDR_I[1:0] == 2'b00);
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && mapped && PSTRB_I[0];
  assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign wbyte     = PWDATA_I[7:0];
  // no wait states; error only in the access phase of an unmapped address
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

  // ---------------------------------------------------------------------------
  // strap synchronisers
  // ---------------------------------------------------------------------------
  // pins are asynchronous; stage 1 feeds stage 2 only
  always_ff @(posedge CLK_I) begin
    strap_s1 <= {SPEED_STRAP_PIN_I, FLOW_CTRL_STRAP_PIN_I,
                 DUPLEX_STRAP_PIN_I};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // a change counts once stages 2 and 3 agree
  always_ff @(posedge CLK_I) begin
    for (int b = 0; b < 3; b++) begin
      if (strap_s2[b] == strap_s3[b]) begin
        strap_f[b] <= strap_s3[b];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------------------
  // while reset is low the strap bits follow the filtered pins, so the
  // value at release is the latched strap; both threshold halves live
  // here so the configuration word has a single writer
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cfg.repeater <= RST_REPEATER;    // see RULE1
      cfg.half_dup <= strap_f[0];      // see RULE4
      cfg.flow_en  <= strap_f[1];      // see RULE5
      cfg.speed10  <= strap_f[2];      // see RULE7
      cfg.null_vid <= RST_NULL_VID;    // see RULE8
      cfg.storm_thr[THR_W-1:8] <= RST_STORM_HI; // see RULE11
      cfg.storm_thr[7:0]       <= RST_STORM_LO; // see RULE11
    end else if (wr_en && idx == IDX_MODE_HI) begin
      cfg.repeater <= wbyte[BIT_REPEATER]; // see RULE1
      cfg.half_dup <= wbyte[BIT_HALF_DUP]; // see RULE4
      cfg.flow_en  <= wbyte[BIT_FLOW_EN];  // see RULE5
      cfg.speed10  <= wbyte[BIT_SPEED10];  // see RULE6
      cfg.null_vid <= wbyte[BIT_NULL_VID]; // see RULE8
      cfg.storm_thr[THR_W-1:8] <= wbyte[STORM_HI_MSB:0]; // see RULE9
    end else if (wr_en && idx == IDX_STORM_LO) begin
      cfg.storm_thr[7:0] <= wbyte;         // see RULE9
    end
  end

  // ---------------------------------------------------------------------------
  // factory test registers
  // ---------------------------------------------------------------------------
  // kept writable; they steer nothing here, software must leave them
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ftest_a <= RST_FTEST_A; // see RULE12
      ftest_b <= RST_FTEST_B; // see RULE12
      ftest_c <= RST_FTEST_C; // see RULE12
    end else if (wr_en) begin
      if (idx == IDX_FTEST_A) begin
        ftest_a <= wbyte;
      end
      if (idx == IDX_FTEST_B) begin
        ftest_b <= wbyte;
      end
      if (idx == IDX_FTEST_C) begin
        ftest_c <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // read mux; unmapped reads as zero
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_MODE_HI: begin
        rd_byte = {cfg.repeater, cfg.half_dup, cfg.flow_en, cfg.speed10,
                   cfg.null_vid, cfg.storm_thr[THR_W-1:8]};
      end
      IDX_STORM_LO: begin
        rd_byte = cfg.storm_thr[7:0];
      end
      IDX_FTEST_A: begin
        rd_byte = ftest_a;
      end
      IDX_FTEST_B: begin
        rd_byte = ftest_b;
      end
      IDX_FTEST_C: begin
        rd_byte = ftest_c;
      end
      IDX_STATUS: begin
        rd_byte = 8'(BCAST_DROP_O);
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    if (PADDR_I[1:0] != 2'b00) begin
      rd_byte = 8'h00;
    end
  end

  // sampled in setup so the data stands through the access phase
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA_O <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------------------
  // mode outputs
  // ---------------------------------------------------------------------------
  // repeater mode trusts software to have set ports per RULE2 and RULE3
  assign REPEATER_EN_O     = cfg.repeater;  // see RULE1
  assign MII_HALF_DUPLEX_O = cfg.half_dup;  // see RULE4
  assign MII_FLOW_CTRL_O   = cfg.flow_en;   // see RULE5
  assign MII_SPEED_10_O    = cfg.speed10;   // see RULE6
  assign STORM_THRESH_O    = cfg.storm_thr; // see RULE9

  // ---------------------------------------------------------------------------
  // null vid replacement
  // ---------------------------------------------------------------------------
  // one cycle of latency; a zero vid takes the ingress port's default
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      VID_VALID_O <= 1'b0;
      VID_O       <= '0;
    end else begin
      VID_VALID_O <= VID_VALID_I;
      if (VID_VALID_I) begin // see RULE8
        VID_O <= (cfg.null_vid && VID_I == '0) ? PORT_VID_I : VID_I;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // tick divider
  // ---------------------------------------------------------------------------
  // millisecond ticks keep the interval counters narrow
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign tick = (div_cnt == DIV_W'(TICK_CYCS - 1));

  // ---------------------------------------------------------------------------
  // storm counting
  // ---------------------------------------------------------------------------
  sgpsc_storm #(
    .NPORTS (NPORTS)
  ) u_storm (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .tick_i    (tick),
    .thr_i     (cfg.storm_thr),
    .port_10_i (PORT_SPEED_10_I),
    .blk_i     (BCAST_BLK_I),
    .drop_o    (BCAST_DROP_O)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_repeater_write: assert property ( // see RULE1
    @(posedge CLK_I) disable iff (!RST_N_I)
    wr_en && idx == IDX_MODE_HI |=> REPEATER_EN_O == $past(PWDATA_I[7]))
    else $error("repeater bit not written");

  a_repeater_reset: assert property ( // see RULE1
    @(posedge CLK_I) !RST_N_I |=> !REPEATER_EN_O)
    else $error("repeater not cleared by reset");

  a_duplex_strap: assert property ( // see RULE4
    @(posedge CLK_I) !RST_N_I ##1 RST_N_I
    |-> MII_HALF_DUPLEX_O == $past(strap_f[0]))
    else $error("duplex strap not latched");

  a_flow_write: assert property ( // see RULE5
    @(posedge CLK_I) disable iff (!RST_N_I)
    wr_en && idx == IDX_MODE_HI |=> MII_FLOW_CTRL_O == $past(PWDATA_I[5]))
    else $error("flow control bit not written");

  a_speed_write: assert property ( // see RULE6
    @(posedge CLK_I) disable iff (!RST_N_I)
    wr_en && idx == IDX_MODE_HI |=> MII_SPEED_10_O == $past(PWDATA_I[4]))
    else $error("speed bit not written");

  a_speed_strap: assert property ( // see RULE7
    @(posedge CLK_I) !RST_N_I ##1 RST_N_I
    |-> MII_SPEED_10_O == $past(strap_f[2]))
    else $error("speed strap not latched");

  a_vid_replace: assert property ( // see RULE8
    @(posedge CLK_I) disable iff (!RST_N_I)
    VID_VALID_I && VID_I == '0 && cfg.null_vid
    |=> VID_VALID_O && VID_O == $past(PORT_VID_I))
    else $error("null vid not replaced");

  a_thresh_join: assert property ( // see RULE9
    @(posedge CLK_I) disable iff (!RST_N_I)
    wr_en && idx == IDX_STORM_LO
    |=> STORM_THRESH_O == {$past(STORM_THRESH_O[10:8]), $past(PWDATA_I[7:0])})
    else $error("threshold low byte not joined");

  a_thresh_reset: assert property ( // see RULE11
    @(posedge CLK_I) !RST_N_I
    |=> STORM_THRESH_O == {RST_STORM_HI, RST_STORM_LO})
    else $error("threshold reset value wrong");

endmodule

// ==== verif/sgpsc_mac_model.sv ====
// Purpose: far-side mac model feeding storm blocks and vid requests
// Assumes: driven by the bench through its tasks, one clock
// Notes:   released vid lines show the inverse of the last value
`timescale 1ns/10ps
module sgpsc_mac_model
  import sgpsc_pkg::*;
(
  // clock
  input  wire logic             clk_i,
  // storm side
  output logic      [2:0]       blk_o,
  output logic      [2:0]       port_10_o,
  // vid side
  output logic                  vid_valid_o,
  output logic      [VID_W-1:0] vid_o,
  output logic      [VID_W-1:0] port_vid_o
);
  // ---------------------------------------------------------------------
  // idle state, port 1 runs at 10BT
  // ---------------------------------------------------------------------
  initial begin
    blk_o       = 3'h0;
    port_10_o   = 3'h2;
    vid_valid_o = 1'b0;
    vid_o       = 12'hFFF;
    port_vid_o  = 12'hFFF;
  end
  // one-cycle block pulses on the ports in m, n in a row
  task automatic send_blocks(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      blk_o <= m;
    end
    @(posedge clk_i);
    blk_o <= 3'h0;
  endtask
  // one vid request; lines scrambled after so stale data never matches
  task automatic send_vid(input logic [11:0] v, input logic [11:0] pv);
    @(posedge clk_i);
    vid_valid_o <= 1'b1;
    vid_o       <= v;
    port_vid_o  <= pv;
    @(posedge clk_i);
    vid_valid_o <= 1'b0;
    vid_o       <= ~v;
    port_vid_o  <= ~pv;
  endtask
endmodule

// ==== verif/tb_switch_global_port_storm_config.sv ====
// Purpose: self-checking bench of the port and storm config bank
// Assumes: TICK_CYCS 4, so intervals are 268 and 2000 cycles
// Notes:   straps set duplex 1, flow 0, speed 1 during reset
`timescale 1ns/10ps
module tb_switch_global_port_storm_config;
  import sgpsc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pready, pslverr, err;
  logic sd, sf, ss, rep, hd, fc, s10, vv, vvo;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [10:0] thr;
  logic [2:0]  p10, blk, drop;
  logic [11:0] vid, pvid, vido;
  int          err_count, tests_run;
  // ---------------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------------
  always #12.5 clk = ~clk;
  sgpsc_top #(.NPORTS(3), .TICK_CYCS(4)) sgpsc_top_i (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .DUPLEX_STRAP_PIN_I(sd), .FLOW_CTRL_STRAP_PIN_I(sf),
    .SPEED_STRAP_PIN_I(ss), .REPEATER_EN_O(rep), .MII_HALF_DUPLEX_O(hd),
    .MII_FLOW_CTRL_O(fc), .MII_SPEED_10_O(s10), .STORM_THRESH_O(thr),
    .PORT_SPEED_10_I(p10), .BCAST_BLK_I(blk), .BCAST_DROP_O(drop),
    .VID_VALID_I(vv), .VID_I(vid), .PORT_VID_I(pvid),
    .VID_VALID_O(vvo), .VID_O(vido));
  sgpsc_mac_model sgpsc_mac_model_i (
    .clk_i(clk), .blk_o(blk), .port_10_o(p10), .vid_valid_o(vv),
    .vid_o(vid), .port_vid_o(pvid));
  // ---------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // apb transfer; holds the request until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [3:0] st);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_drop(int b, logic v, int lim);
    for (int i = 0; i < lim && drop[b] !== v; i++) @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    apb(0, 8'h18, 0, 4'hF);
    chk("mode", rd, 32'h50);
    chk("rep", rep, 0);
    chk("half", hd, 1);
    chk("flow", fc, 0);
    chk("spd10", s10, 1);
    chk("thr", thr, 11'h063);
    apb(0, 8'h1C, 0, 4'hF);
    chk("low", rd, 32'h63);
    // factory registers are only read, never written
    apb(0, 8'h20, 0, 4'hF);
    chk("fta", rd, 32'h00);
    apb(0, 8'h24, 0, 4'hF);
    chk("ftb", rd, 32'h24);
    apb(0, 8'h28, 0, 4'hF);
    chk("ftc", rd, 32'h35);
  endtask
  // port setup for repeater mode is outside this bank
  task automatic t_mode;
    apb(1, 8'h18, 32'h8F, 4'hF);
    #1;
    chk("rep", rep, 1);
    chk("half", hd, 0);
    chk("spd10", s10, 0);
    chk("thr", thr, 11'h763);
    apb(1, 8'h18, 32'h34, 4'hF);
    #1;
    chk("flow", fc, 1);
    chk("spd10", s10, 1);
    chk("thr", thr, 11'h463);
    apb(0, 8'h18, 0, 4'hF);
    chk("mode", rd, 32'h34);
  endtask
  task automatic t_vid;
    apb(1, 8'h18, 32'h08, 4'hF);
    sgpsc_mac_model_i.send_vid(12'h000, 12'hABC);
    #1;
    chk("vvalid", vvo, 1);
    chk("vid", vido, 12'hABC);
    sgpsc_mac_model_i.send_vid(12'h005, 12'hABC);
    #1;
    chk("vid", vido, 12'h005);
    apb(1, 8'h18, 32'h00, 4'hF);
    sgpsc_mac_model_i.send_vid(12'h000, 12'hABC);
    #1;
    chk("vid", vido, 12'h000);
  endtask
  task automatic t_storm;
    apb(1, 8'h1C, 32'h02, 4'hF);
    #1;
    chk("thr", thr, 11'h002);
    sgpsc_mac_model_i.send_blocks(3'h3, 2);
    repeat (3) @(posedge clk);
    #1;
    chk("drop", drop, 3'h0);
    sgpsc_mac_model_i.send_blocks(3'h3, 1);
    @(posedge clk);
    #1;
    chk("drop", drop, 3'h3);
    apb(0, 8'h40, 0, 4'hF);
    chk("status", rd, 32'h3);
    wait_drop(0, 0, 280);
    chk("drop100", drop, 3'h2);
    wait_drop(1, 0, 2100);
    chk("drop10", drop, 3'h0);
  endtask
  task automatic t_refuse;
    apb(0, 8'h30, 0, 4'hF);
    chk("slverr", err, 1);
    chk("ready", pready, 1);
    chk("unmapped", rd, 32'h0);
    apb(1, 8'h1C, 32'h11, 4'h0);
    apb(0, 8'h1C, 0, 4'hF);
    chk("nostrb", rd, 32'h02);
  endtask
  // ---------------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end
  initial begin
    clk = 0;
    rst_n = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 0;
    sd = 1;
    sf = 0;
    ss = 1;
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_mode;
    t_vid;
    t_storm;
    t_refuse;
    end_sim;
  end
endmodule
